// ==== hdl/mpch_pkg.sv ====
package mpch_pkg;
	localparam int MPCH_DATA_W = 16;
	localparam int MPCH_ADDR_W = 15;
	localparam logic MPCH_RST_FAULT = 1'b0;
	localparam logic MPCH_RST_HALT = 1'b0;
	localparam logic MPCH_RST_PBIT = 1'b0;
	localparam logic [MPCH_DATA_W-1:0] MPCH_RST_DATA = 16'h0000;
	localparam logic [MPCH_ADDR_W-1:0] MPCH_RST_ADDR = 15'h0000;
	localparam int MPCH_PIPE_STAGES = 2;
	typedef enum logic [1:0] {
		MPCH_RESP_IGNORE = 2'b01,
		MPCH_RESP_STOP = 2'b10
	} mpch_resp_t;
endpackage

// ==== hdl/mpch_check.sv ====
// Behaviour
// (R1) stop position plus read parity mismatch halts the processor
// (R2) violation register latches current address, may be one or two past fault
// (R3) on indirect access latched address may lie in another module
// (R4) data plus parity must hold even ones, else parity fault
// (R5) internal preset clears the latched parity fault indication
// (R6) cycle, step and bump operations rewrite parity; manual display does not
// (R7) parity bit of last read word shown beside display data
// (R8) every write generates parity giving even ones overall
`timescale 1ns/10ps
module mpch_check #(
	parameter int DATA_W = mpch_pkg::MPCH_DATA_W,
	parameter int ADDR_W = mpch_pkg::MPCH_ADDR_W
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic stop_on_fault,
	input wire logic internal_preset,
	input wire logic mem_rd_valid,
	input wire logic [DATA_W-1:0] mem_rd_data,
	input wire logic mem_rd_parity,
	input wire logic [ADDR_W-1:0] cur_addr,
	input wire logic mem_wr_en,
	input wire logic [DATA_W-1:0] mem_wr_data,
	input wire logic panel_cycle_op,
	output logic mem_wr_parity,
	output logic mem_wr_commit,
	output logic parity_fault,
	output logic processor_halt,
	output logic [ADDR_W-1:0] violation_addr,
	output logic [DATA_W-1:0] display_data,
	output logic display_parity
);
	import mpch_pkg::*;

	// the state struct takes its widths from the package, no other width is served
	if (DATA_W != MPCH_DATA_W) begin : g_bad_data_w
		$error("mpch_check: DATA_W must equal MPCH_DATA_W");
	end

	if (ADDR_W != MPCH_ADDR_W) begin : g_bad_addr_w
		$error("mpch_check: ADDR_W must equal MPCH_ADDR_W");
	end

	// one stage would let a metastable level reach the fault logic
	if (MPCH_PIPE_STAGES < 2) begin : g_bad_sync
		$error("mpch_check: panel switches need two sync stages");
	end

	// all state of the block in one register
	typedef struct packed {
		logic [MPCH_PIPE_STAGES-1:0] stop_sync;
		logic [MPCH_PIPE_STAGES-1:0] preset_sync;
		logic preset_prev;
		logic fault;
		logic halt;
		logic [MPCH_ADDR_W-1:0] vaddr;
		logic [MPCH_DATA_W-1:0] ddata;
		logic dpar;
		logic wpar;
		logic wcommit;
	} mpch_state_t;

	// value loaded while reset_n is low
	localparam mpch_state_t MPCH_STATE_RST = '{
		stop_sync: '0,
		preset_sync: '0,
		preset_prev: 1'b0,
		fault: MPCH_RST_FAULT,
		halt: MPCH_RST_HALT,
		vaddr: MPCH_RST_ADDR,
		ddata: MPCH_RST_DATA,
		dpar: MPCH_RST_PBIT,
		wpar: 1'b0,
		wcommit: 1'b0
	};

	mpch_state_t s_q;
	mpch_state_t s_d;

	// even parity: the bit makes the total count of ones even
	function automatic logic mpch_gen_parity(input logic [MPCH_DATA_W-1:0] d);
		logic acc;
		acc = 1'b0;
		for (int i = 0; i < MPCH_DATA_W; i++) begin
			acc = acc ^ d[i];
		end
		return acc;
	endfunction

	// odd count of ones over data plus parity marks a bad word
	function automatic logic mpch_word_bad(
		input logic [MPCH_DATA_W-1:0] d,
		input logic p
	);
		return mpch_gen_parity(d) ^ p;
	endfunction

	// one step of a sync chain; the pin enters at bit 0
	function automatic logic [MPCH_PIPE_STAGES-1:0] mpch_sync_step(
		input logic [MPCH_PIPE_STAGES-1:0] chain,
		input logic pin
	);
		return {chain[MPCH_PIPE_STAGES-2:0], pin};
	endfunction

	// switch level to response mode
	function automatic mpch_resp_t mpch_resp_of(
		input logic level
	);
		if (level) begin
			return MPCH_RESP_STOP;
		end else begin
			return MPCH_RESP_IGNORE;
		end
	endfunction

	// next halt level; a repeat fault keeps any halt that preset left
	function automatic logic mpch_next_halt(
		input logic keep,
		input logic stop
	);
		return keep || stop;
	endfunction

	logic rd_bad;
	logic mismatch;
	logic stop_mode;
	mpch_resp_t resp_mode;
	logic halt_on_fault;
	logic preset_level;
	logic preset_pulse;
	logic first_fault;
	logic repeat_fault;
	logic halt_keep;
	logic wr_par_d;
	logic wr_commit_d;

	// read side
	assign rd_bad = mpch_word_bad(mem_rd_data, mem_rd_parity); // see (R4)
	assign mismatch = mem_rd_valid && rd_bad; // see (R4)

	// only the second flip-flop of each chain is read by logic
	assign stop_mode = s_q.stop_sync[MPCH_PIPE_STAGES-1];
	assign preset_level = s_q.preset_sync[MPCH_PIPE_STAGES-1];

	assign resp_mode = mpch_resp_of(stop_mode);
	assign halt_on_fault = (resp_mode == MPCH_RESP_STOP); // see (R1)

	// preset acts on its edge, so a held switch does not mask later faults
	assign preset_pulse = preset_level && !s_q.preset_prev; // see (R5)

	// only the first fault since preset may load the address
	assign first_fault = mismatch && !s_q.fault;
	assign repeat_fault = mismatch && s_q.fault;
	assign halt_keep = s_q.halt && !preset_pulse;

	// write side
	assign wr_par_d = mpch_gen_parity(mem_wr_data); // see (R8)
	assign wr_commit_d = mem_wr_en && panel_cycle_op; // see (R6)

	always_comb begin
		s_d = s_q;

		// panel switches are asynchronous, so both pass a two-stage sync
		s_d.stop_sync = mpch_sync_step(s_q.stop_sync, stop_on_fault);
		s_d.preset_sync = mpch_sync_step(s_q.preset_sync, internal_preset);
		s_d.preset_prev = preset_level;

		// display keeps the last word read, good or bad
		if (mem_rd_valid) begin
			s_d.ddata = mem_rd_data; // see (R7)
			s_d.dpar = mem_rd_parity; // see (R7)
		end

		// preset first, so a fault in the same cycle wins over it
		if (preset_pulse) begin
			s_d.fault = 1'b0; // see (R5)
			s_d.halt = 1'b0; // see (R5)
		end

		if (first_fault) begin
			s_d.fault = 1'b1; // see (R4)
			// address is whatever the sequencer holds now; no rewind by design
			s_d.vaddr = cur_addr; // see (R2) see (R3)
			s_d.halt = mpch_next_halt(1'b0, halt_on_fault); // see (R1)
		end else if (repeat_fault) begin
			// the first address stays, but a later fault may still stop the machine
			s_d.fault = 1'b1; // see (R4)
			s_d.halt = mpch_next_halt(halt_keep, halt_on_fault); // see (R1)
		end

		// manual display and load writes get parity but no commit
		s_d.wcommit = wr_commit_d; // see (R6)
		if (mem_wr_en) begin
			s_d.wpar = wr_par_d; // see (R8)
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= MPCH_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// memory write side
	assign mem_wr_parity = s_q.wpar;
	assign mem_wr_commit = s_q.wcommit;

	// panel indicators
	assign parity_fault = s_q.fault;
	assign processor_halt = s_q.halt;
	assign violation_addr = s_q.vaddr;

	// display register and its parity lamp
	assign display_data = s_q.ddata;
	assign display_parity = s_q.dpar;

endmodule

// ==== tb/mpch_asserts.sv ====
`timescale 1ns/10ps
module mpch_asserts(input wire logic mclk,reset_n,internal_preset,mem_rd_valid,
	mem_rd_parity,mem_wr_en,panel_cycle_op,mem_wr_parity,mem_wr_commit,parity_fault,
	processor_halt,display_parity,input wire logic [15:0] mem_rd_data,mem_wr_data,
	input wire logic [14:0] cur_addr,violation_addr);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
wire bad=mem_rd_valid&&^{mem_rd_data,mem_rd_parity};
rd_bad_a: assert property (bad |=> parity_fault) else $error("miss");
halt_why_a: assert property (processor_halt |-> parity_fault) else $error("halt");
addr_latch_a:
	assert property ($rose(parity_fault) |-> violation_addr==$past(cur_addr)) else $error("va");
addr_hold_a:
	assert property (parity_fault[*2] |-> $stable(violation_addr)) else $error("va moved");
preset_clr_a:
	assert property ($rose(internal_preset) |-> ##[1:6] !parity_fault) else $error("pr");
wr_par_a:
	assert property (mem_wr_en |=> !(^{mem_wr_parity,$past(mem_wr_data)})) else $error("wp");
wr_commit_a:
	assert property (mem_wr_en |=> mem_wr_commit==$past(panel_cycle_op)) else $error("wc");
disp_par_a:
	assert property (mem_rd_valid |=> display_parity==$past(mem_rd_parity)) else $error("dp");
cover property (processor_halt);
cover property (mem_wr_commit);
cover property ($fell(parity_fault));
endmodule

// ==== tb/mpch_core_mem.sv ====
`timescale 1ns/10ps
module mpch_core_mem(input wire logic mclk,wr,par,bad,input wire logic [15:0] wd,
	input wire logic [1:0] a,output logic [15:0] rd,output logic rp);
logic [16:0] m[4];
always @(posedge mclk) if (wr) m[a]<={par,wd};
// bad flips the stored parity only when the bench asks for it
assign {rp,rd}=m[a]^{bad,16'h0000};
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
logic mclk=0,reset_n=0,pre=0,stp=1,rv=0,we=0,op=1,fl=0,ef=0,wp,wc,pf,ph,mp,dp;
logic [15:0] wd=0,dd,md,rm[4];
logic [14:0] ca=0,va,ev=0;
logic [31:0] s=22503;
int n_errors=0,comparisons=0,cyc=0;
always #2 mclk=~mclk;
// ceiling well above the ~28 cycles the tests take
always @(posedge mclk) if (++cyc>300) begin n_errors++; close_out; end
mpch_check dut_u(.mclk,.reset_n,.stop_on_fault(stp),.internal_preset(pre),.mem_rd_valid(rv),
	.mem_rd_data(md),.mem_rd_parity(mp),.cur_addr(ca),.mem_wr_en(we),.mem_wr_data(wd),
	.panel_cycle_op(op),.mem_wr_parity(wp),.mem_wr_commit(wc),.parity_fault(pf),
	.processor_halt(ph),.violation_addr(va),.display_data(dd),.display_parity(dp));
mpch_core_mem mem_u(.mclk,.wr(wc),.par(wp),.bad(fl),.wd,.a(ca[1:0]),.rd(md),.rp(mp));
function logic [15:0] xs; s^=s<<13; s^=s>>17; s^=s<<5; return s[15:0]; endfunction
task t; @(posedge mclk); #1; endtask
task chk(string n,logic [15:0] v,e); comparisons++; if (v!==e) begin n_errors++;
	$display("ERROR %s exp %h seen %h",n,e,v); end endtask
task close_out; $display("checks %0d errors %0d",comparisons,n_errors);
	if (n_errors==0&&comparisons>0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish; endtask
initial begin
	repeat(6) t; reset_n=1;
	// last pass is a manual write, so memory must keep the older word
	for (int i=0;i<5;i++) begin
		ca=15'(i%4); wd=xs(); op=i<4; we=1; t; we=0;
		chk("commit",wc,op);
		chk("wpar",wp,^wd);
		t; if (op) rm[i%4]=wd;
		fl=i>1; rv=1; t; rv=0; if (!ef&&fl) ev=ca; ef|=fl;
		chk("data",dd,rm[i%4]);
		chk("dpar",dp,(^rm[i%4])^fl);
		chk("fault",pf,ef);
		chk("halt",ph,ef);
		chk("addr",va,ev);
		fl=0; $display("test %0d done",i);
	end
	// preset clears; ignore mode then records a fresh fault without halting
	pre=1; stp=0; repeat(6) t;
	chk("clear",pf,0);
	chk("unhalt",ph,0);
	pre=0; ca=15'h0003; fl=1; rv=1; t; rv=0;
	chk("refault",pf,1);
	chk("ignore",ph,0);
	chk("addr2",va,15'h0003);
	fl=0; $display("test preset done");
	close_out;
end
endmodule
bind mpch_check mpch_asserts chk_u(.mclk(mclk),.reset_n(reset_n),.internal_preset(internal_preset),
	.mem_rd_valid(mem_rd_valid),.mem_rd_parity(mem_rd_parity),.mem_wr_en(mem_wr_en),
	.panel_cycle_op(panel_cycle_op),.mem_wr_parity(mem_wr_parity),.mem_wr_commit(mem_wr_commit),
	.parity_fault(parity_fault),.processor_halt(processor_halt),.display_parity(display_parity),
	.mem_rd_data(mem_rd_data),.mem_wr_data(mem_wr_data),.cur_addr(cur_addr),
	.violation_addr(violation_addr));
